// >>> design/pwr_mode_pkg.sv
// power mode controller constants, types and register map
// What this block does
// [RQ1] wait instruction stops cpu clock
// [RQ2] wait entry clears interrupt mask bit
// [RQ3] interrupt in wait resumes with stacking
// [RQ4] wait keeps bus clocks and full regulation
// [RQ5] wait allows only background and status commands
// [RQ6] status commands in low power return error
// [RQ7] background command wakes wait into debug
// [RQ8] stop enters stop3 only when permitted
// [RQ9] stop3 halts clocks except requested oscillators
// [RQ10] stop3 puts clock, regulator, converter standby
// [RQ11] stop3 preserves state, pins held by logic
// [RQ12] stop3 exits on reset or wake sources
// [RQ13] reset exit fetches reset vector, else irq
// [RQ14] reset starts at vector 0xFFFE:0xFFFF
// [RQ15] rtc on low power osc, off when zero
// [RQ16] run to background needs debug permit
// [RQ17] debug permit keeps debug clock and regulation
// [RQ18] stop background wake only with permit
// [RQ19] background mode accepts all debug commands
// [RQ20] voltage detect in stop keeps regulator active
// [RQ21] stop instruction also clears interrupt mask
// [RQ22] cpu clock restored before stacking or fetch
package pwr_mode_pkg;
    localparam logic [7:0]  OFS_SYS_OPTION  = 8'h00;
    localparam logic [7:0]  OFS_DBG_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_PWR_CTRL1   = 8'h08;
    localparam logic [7:0]  OFS_RTC_CTRL2   = 8'h0C;
    localparam logic [7:0]  OFS_MODE_STATUS = 8'h10;
    localparam int          BIT_STOP_PERMIT = 0;
    localparam int          BIT_XOSC_STOP   = 1;
    localparam int          BIT_IREF_STOP   = 2;
    localparam int          BIT_DBG_PERMIT  = 0;
    localparam int          BIT_VD_EN       = 0;
    localparam int          BIT_VD_STOP_EN  = 1;
    localparam int          RTC_PRESCALE_SELECT_W         = 4;
    localparam logic [31:0] SYS_OPTION_RST  = 32'h0000_0000;
    localparam logic [31:0] DBG_STATUS_RST  = 32'h0000_0000;
    localparam logic [31:0] PWR_CTRL1_RST   = 32'h0000_0000;
    localparam logic [31:0] RTC_CTRL2_RST   = 32'h0000_0000;
    localparam logic [15:0] RESET_VECTOR    = 16'hFFFE;
    localparam int          WAKE_W          = 7;
    localparam int          CLK_RESTORE_CYC = 2;
    localparam int          CLK_MHZ         = 25;
    localparam int          LPO_HZ          = 1000;
    localparam int          LPO_DIV         = CLK_MHZ * 1000000 / LPO_HZ;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_WAIT    = 3'b001,
        ST_STOP3   = 3'b011,
        ST_RESTORE = 3'b010,
        ST_BDM     = 3'b110
    } pmode_t;

    typedef enum logic [1:0] {
        CMD_BACKGROUND = 2'h0,
        CMD_MEM_STATUS = 2'h1,
        CMD_OTHER      = 2'h2
    } dbg_cmd_t;

    typedef enum logic [1:0] {
        RESUME_NONE  = 2'h0,
        RESUME_IRQ   = 2'h1,
        RESUME_RESET = 2'h2,
        RESUME_BDM   = 2'h3
    } resume_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic bus_clk_en;
        logic dbg_clk_en;
        logic xosc_en;
        logic iref_en;
        logic clkgen_standby;
        logic reg_full;
        logic adc_standby;
        logic hold_state;
    } pwr_ctrl_t;

    typedef struct packed {
        logic     valid;
        dbg_cmd_t cmd;
    } dbg_req_t;

    typedef struct packed {
        logic accept;
        logic reject;
        logic err_lowpower;
        logic mem_access;
    } dbg_rsp_t;
endpackage

// >>> design/low_power_mode_control.sv
// power mode controller: run, wait, stop3, background debug, apb registers
//
// The APB register port and the register addresses were decided locally.
module low_power_mode_control
    import pwr_mode_pkg::*;
#(
    parameter int LPO_DIV_P = LPO_DIV
) (
    input  wire  logic                      clk,
    input  wire  logic                      resetn,
    input  wire  logic                      psel,
    input  wire  logic                      penable,
    input  wire  logic                      pwrite,
    input  wire  logic [7:0]                paddr,
    input  wire  logic [31:0]               pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire  logic                      wait_exec,
    input  wire  logic                      stop_exec,
    input  wire  logic                      int_req,
    input  wire  logic                      reset_pin,
    input  wire  logic [WAKE_W-1:0]         wake_src,
    input  wire  pwr_mode_pkg::dbg_req_t    dbg_req,
    output pwr_mode_pkg::dbg_rsp_t          dbg_rsp,
    output pwr_mode_pkg::pwr_ctrl_t         pwr_ctrl,
    output pwr_mode_pkg::pmode_t            mode,
    output logic                            clear_imask,
    output logic                            resume_go,
    output pwr_mode_pkg::resume_t           resume_kind,
    output logic [15:0]                     fetch_vector,
    output logic                            lpo_tick,
    output logic                            rtc_clk_en
);
    import pwr_mode_pkg::*;

    logic [31:0] sys_option_reg;
    logic [31:0] debug_status_control_reg;
    logic [31:0] power_status_ctrl1;
    logic [31:0] rtc_status_control2;
    pmode_t      mode_reg;
    pmode_t      mode_next;
    resume_t     pend_reg;
    resume_t     pend_next;
    logic [1:0]  restore_cnt_reg;
    logic [31:0] lpo_cnt_reg;
    logic        stop_dbg_reg;
    logic        stop_vd_reg;
    logic        apb_wr;
    logic        map_hit;

    wire stop_mode_permit  = sys_option_reg[BIT_STOP_PERMIT];
    wire debug_mode_permit = debug_status_control_reg[BIT_DBG_PERMIT];
    wire [RTC_PRESCALE_SELECT_W-1:0] rtc_prescale_select = rtc_status_control2[RTC_PRESCALE_SELECT_W-1:0];
    wire bg_cmd = dbg_req.valid && dbg_req.cmd == CMD_BACKGROUND;
    wire any_wake = |wake_src;

    // apb slave: zero wait states, unmapped address answers with pslverr
    assign pready = 1'b1;
    assign apb_wr = psel && penable && pwrite;
    always_comb begin
        case (paddr)
            OFS_SYS_OPTION, OFS_DBG_STATUS, OFS_PWR_CTRL1, OFS_RTC_CTRL2, OFS_MODE_STATUS: map_hit = 1'b1;
            default: map_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !map_hit;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sys_option_reg           <= SYS_OPTION_RST;
            debug_status_control_reg <= DBG_STATUS_RST;
            power_status_ctrl1       <= PWR_CTRL1_RST;
            rtc_status_control2      <= RTC_CTRL2_RST;
        end else if (apb_wr) begin
            case (paddr)
                OFS_SYS_OPTION: sys_option_reg <= {29'h0, pwdata[2:0]};
                OFS_DBG_STATUS: debug_status_control_reg <= {31'h0, pwdata[0]};
                OFS_PWR_CTRL1:  power_status_ctrl1 <= {30'h0, pwdata[1:0]};
                OFS_RTC_CTRL2:  rtc_status_control2 <= {28'h0, pwdata[RTC_PRESCALE_SELECT_W-1:0]};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_SYS_OPTION:  prdata <= sys_option_reg;
                OFS_DBG_STATUS:  prdata <= debug_status_control_reg;
                OFS_PWR_CTRL1:   prdata <= power_status_ctrl1;
                OFS_RTC_CTRL2:   prdata <= rtc_status_control2;
                OFS_MODE_STATUS: prdata <= {25'h0, pend_reg, stop_dbg_reg, stop_vd_reg, mode_reg};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // mode sequencer
    always_comb begin
        mode_next = mode_reg;
        pend_next = pend_reg;
        case (mode_reg)
            ST_RUN: begin
                if (bg_cmd && debug_mode_permit) begin
                    mode_next = ST_BDM;              // [RQ16]
                end else if (wait_exec) begin
                    mode_next = ST_WAIT;             // [RQ1]
                end else if (stop_exec && stop_mode_permit) begin
                    mode_next = ST_STOP3;            // [RQ8]
                end
            end
            ST_WAIT: begin
                if (reset_pin) begin
                    mode_next = ST_RESTORE;
                    pend_next = RESUME_RESET;
                end else if (bg_cmd) begin
                    mode_next = ST_RESTORE;          // [RQ7]
                    pend_next = RESUME_BDM;
                end else if (int_req || any_wake) begin
                    mode_next = ST_RESTORE;          // [RQ3]
                    pend_next = RESUME_IRQ;
                end
            end
            ST_STOP3: begin
                if (reset_pin) begin
                    mode_next = ST_RESTORE;          // [RQ12] [RQ13]
                    pend_next = RESUME_RESET;
                end else if (bg_cmd && debug_mode_permit) begin
                    mode_next = ST_RESTORE;          // [RQ18]
                    pend_next = RESUME_BDM;
                end else if (any_wake) begin
                    mode_next = ST_RESTORE;          // [RQ12]
                    pend_next = RESUME_IRQ;
                end
            end
            ST_RESTORE: begin
                // cpu clock runs here; the resume pulse only fires after the count
                if (restore_cnt_reg == 2'(CLK_RESTORE_CYC - 1)) begin
                    mode_next = (pend_reg == RESUME_BDM) ? ST_BDM : ST_RUN;  // [RQ22]
                    pend_next = RESUME_NONE;
                end
            end
            ST_BDM: begin
                if (reset_pin) begin
                    mode_next = ST_RUN;
                end
            end
            default: mode_next = ST_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_reg <= ST_RUN;
            pend_reg <= RESUME_NONE;
        end else begin
            mode_reg <= mode_next;
            pend_reg <= pend_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || mode_reg != ST_RESTORE) begin
            restore_cnt_reg <= 2'h0;
        end else begin
            restore_cnt_reg <= restore_cnt_reg + 2'h1;
        end
    end

    // stop-time options are caught when the stop instruction executes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stop_dbg_reg <= 1'b0;
            stop_vd_reg  <= 1'b0;
        end else if (mode_reg == ST_RUN && stop_exec && stop_mode_permit) begin
            stop_dbg_reg <= debug_mode_permit;                                     // [RQ17]
            stop_vd_reg  <= power_status_ctrl1[BIT_VD_EN] && power_status_ctrl1[BIT_VD_STOP_EN];  // [RQ20]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            clear_imask <= 1'b0;
        end else begin
            clear_imask <= mode_reg == ST_RUN && mode_next != ST_RUN && mode_next != ST_BDM;  // [RQ2] [RQ21]
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            resume_go    <= 1'b0;
            resume_kind  <= RESUME_RESET;
            fetch_vector <= RESET_VECTOR;            // [RQ14]
        end else begin
            resume_go <= mode_reg == ST_RESTORE && mode_next != ST_RESTORE;
            if (mode_reg == ST_RESTORE && mode_next != ST_RESTORE) begin
                resume_kind <= pend_reg;             // [RQ13]
                if (pend_reg == RESUME_RESET) begin
                    fetch_vector <= RESET_VECTOR;    // [RQ14]
                end
            end
        end
    end

    // clock and power gating; state retention is the held register contents
    always_comb begin
        pwr_ctrl = '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, dbg_clk_en: 1'b1, xosc_en: 1'b1,
                     iref_en: 1'b1, clkgen_standby: 1'b0, reg_full: 1'b1, adc_standby: 1'b0,
                     hold_state: 1'b0};
        case (mode_reg)
            ST_WAIT: pwr_ctrl.cpu_clk_en = 1'b0;     // [RQ1] [RQ4]
            ST_STOP3: begin
                pwr_ctrl.cpu_clk_en     = 1'b0;      // [RQ9]
                pwr_ctrl.bus_clk_en     = 1'b0;
                pwr_ctrl.dbg_clk_en     = stop_dbg_reg;                      // [RQ17]
                pwr_ctrl.xosc_en        = sys_option_reg[BIT_XOSC_STOP];     // [RQ9]
                pwr_ctrl.iref_en        = sys_option_reg[BIT_IREF_STOP];
                pwr_ctrl.clkgen_standby = 1'b1;      // [RQ10]
                pwr_ctrl.adc_standby    = 1'b1;
                pwr_ctrl.reg_full       = stop_dbg_reg || stop_vd_reg;      // [RQ10] [RQ17] [RQ20]
                pwr_ctrl.hold_state     = 1'b1;      // [RQ11]
            end
            default: ;
        endcase
    end

    assign mode = mode_reg;

    // debug command filter
    always_comb begin
        dbg_rsp = '0;
        if (dbg_req.valid) begin
            case (mode_reg)
                ST_WAIT, ST_STOP3: begin
                    if (dbg_req.cmd == CMD_MEM_STATUS) begin
                        dbg_rsp.accept       = 1'b1;  // [RQ5] [RQ6]
                        dbg_rsp.err_lowpower = 1'b1;
                    end else if (bg_cmd && (mode_reg == ST_WAIT || debug_mode_permit)) begin
                        dbg_rsp.accept = 1'b1;        // [RQ5] [RQ18]
                    end else begin
                        dbg_rsp.reject = 1'b1;        // [RQ5] [RQ18]
                    end
                end
                ST_BDM: begin
                    dbg_rsp.accept     = 1'b1;        // [RQ19]
                    dbg_rsp.mem_access = dbg_req.cmd == CMD_MEM_STATUS;
                end
                default: begin
                    dbg_rsp.accept     = !bg_cmd || debug_mode_permit;
                    dbg_rsp.reject     = bg_cmd && !debug_mode_permit;  // [RQ16]
                    dbg_rsp.mem_access = dbg_req.cmd == CMD_MEM_STATUS;
                end
            endcase
        end
    end

    // low power oscillator tick and rtc clock enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            lpo_cnt_reg <= 32'h0000_0000;
            lpo_tick    <= 1'b0;
        end else if (lpo_cnt_reg == 32'(LPO_DIV_P - 1)) begin
            lpo_cnt_reg <= 32'h0000_0000;
            lpo_tick    <= 1'b1;
        end else begin
            lpo_cnt_reg <= lpo_cnt_reg + 32'h0000_0001;
            lpo_tick    <= 1'b0;
        end
    end
    assign rtc_clk_en = lpo_tick && rtc_prescale_select != '0;  // [RQ15]

    a_wait_cpu_gated: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_WAIT |-> !pwr_ctrl.cpu_clk_en && pwr_ctrl.bus_clk_en && pwr_ctrl.reg_full)
        else $error("wait gating wrong"); // [RQ1] [RQ4]
    a_stop_permit: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_RUN && stop_exec && !wait_exec && !bg_cmd && !stop_mode_permit |=> mode_reg == ST_RUN)
        else $error("stop taken without permit"); // [RQ8]
    a_stop_enter: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_RUN && stop_exec && !wait_exec && !bg_cmd && stop_mode_permit |=> mode_reg == ST_STOP3 ##0 clear_imask)
        else $error("stop entry wrong"); // [RQ21]
    a_wait_imask: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_RUN && wait_exec && !bg_cmd |=> clear_imask)
        else $error("wait did not clear mask"); // [RQ2]
    a_irq_resume: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_WAIT && int_req && !reset_pin && !bg_cmd |=> ##2 resume_go && resume_kind == RESUME_IRQ && pwr_ctrl.cpu_clk_en)
        else $error("irq resume wrong"); // [RQ3] [RQ22]
    a_stop_status_err: assert property (@(posedge clk) disable iff (!resetn)
        dbg_req.valid && dbg_req.cmd == CMD_MEM_STATUS && (mode_reg == ST_WAIT || mode_reg == ST_STOP3)
        |-> dbg_rsp.err_lowpower && !dbg_rsp.mem_access)
        else $error("status command accessed memory"); // [RQ6]
    a_wait_other_rej: assert property (@(posedge clk) disable iff (!resetn)
        dbg_req.valid && dbg_req.cmd == CMD_OTHER && mode_reg == ST_WAIT |-> dbg_rsp.reject)
        else $error("wait accepted other command"); // [RQ5]
    a_stop_bg_noperm: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_STOP3 && bg_cmd && !debug_mode_permit && !reset_pin && !any_wake |=> mode_reg == ST_STOP3)
        else $error("stop woke without permit"); // [RQ18]
    a_reset_vector: assert property (@(posedge clk) disable iff (!resetn)
        resume_go && resume_kind == RESUME_RESET |-> fetch_vector == RESET_VECTOR)
        else $error("reset vector wrong"); // [RQ13] [RQ14]
    a_rtc_off: assert property (@(posedge clk) disable iff (!resetn)
        rtc_prescale_select == '0 |-> !rtc_clk_en)
        else $error("rtc clocked while disabled"); // [RQ15]
    a_bdm_all: assert property (@(posedge clk) disable iff (!resetn)
        mode_reg == ST_BDM && dbg_req.valid |-> dbg_rsp.accept)
        else $error("debug mode refused command"); // [RQ19]
    c_wait_irq: cover property (@(posedge clk) disable iff (!resetn) mode_reg == ST_WAIT ##1 mode_reg == ST_RESTORE);
    c_stop_wake: cover property (@(posedge clk) disable iff (!resetn) mode_reg == ST_STOP3 ##1 mode_reg == ST_RESTORE);
    c_stop_bdm: cover property (@(posedge clk) disable iff (!resetn) mode_reg == ST_STOP3 && bg_cmd && debug_mode_permit);
    c_run_bdm: cover property (@(posedge clk) disable iff (!resetn) mode_reg == ST_RUN ##1 mode_reg == ST_BDM);
endmodule

// >>> tb/cpu_side_model.sv
// model of the cpu core, wake sources and debug host that drive the mode inputs
module cpu_side_model
    import pwr_mode_pkg::*;
(
    input  wire logic                   clk,
    output logic                        wait_exec,
    output logic                        stop_exec,
    output logic                        int_req,
    output logic                        reset_pin,
    output logic [WAKE_W-1:0]           wake_src,
    output pwr_mode_pkg::dbg_req_t      dbg_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wait_exec = 1'b0;
        stop_exec = 1'b0;
        int_req   = 1'b0;
        reset_pin = 1'b0;
        wake_src  = '0;
        dbg_req   = '0;
    end
    // instruction strobes last exactly one cycle, like a real fetch
    task automatic exec(input logic is_stop);
        @(posedge clk);
        if (is_stop) stop_exec <= 1'b1;
        else wait_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        wait_exec <= 1'b0;
    endtask
    task automatic levels(input logic irq, input logic rst, input logic [WAKE_W-1:0] src);
        @(posedge clk);
        int_req   <= irq;
        reset_pin <= rst;
        wake_src  <= src;
    endtask
    task automatic debug(input logic v, input dbg_cmd_t c);
        @(posedge clk);
        dbg_req <= {v, c};
    endtask
endmodule

// >>> tb/test_low_power_mode_control.sv
// self-checking bench for the power mode controller
module test_low_power_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    import pwr_mode_pkg::*;
    localparam int LPO_SIM = 10;
    localparam int LIMIT   = 4000;
    logic              clk = 1'b0;
    logic              resetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              wait_exec;
    logic              stop_exec;
    logic              int_req;
    logic              reset_pin;
    logic [WAKE_W-1:0] wake_src;
    dbg_req_t          dbg_req;
    dbg_rsp_t          dbg_rsp;
    pwr_ctrl_t         pwr_ctrl;
    pmode_t            mode;
    logic              clear_imask;
    logic              resume_go;
    resume_t           resume_kind;
    logic [15:0]       fetch_vector;
    logic              lpo_tick;
    logic              rtc_clk_en;
    int                num_errors = 0;
    int                tests_run = 0;
    int                cycles = 0;

    always #20 clk = ~clk;
    low_power_mode_control #(.LPO_DIV_P(LPO_SIM)) dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wait_exec(wait_exec),
        .stop_exec(stop_exec), .int_req(int_req), .reset_pin(reset_pin), .wake_src(wake_src),
        .dbg_req(dbg_req), .dbg_rsp(dbg_rsp), .pwr_ctrl(pwr_ctrl), .mode(mode), .clear_imask(clear_imask),
        .resume_go(resume_go), .resume_kind(resume_kind), .fetch_vector(fetch_vector),
        .lpo_tick(lpo_tick), .rtc_clk_en(rtc_clk_en)
    );
    cpu_side_model cpu (
        .clk(clk), .wait_exec(wait_exec), .stop_exec(stop_exec), .int_req(int_req),
        .reset_pin(reset_pin), .wake_src(wake_src), .dbg_req(dbg_req)
    );

    task automatic wrap_up;
        if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(what, exp, rd);
    endtask
    task automatic wait_mode(input pmode_t m);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (mode !== m && n < 20);
        check("mode", m, mode);
    endtask
    task automatic dbg_chk(input dbg_cmd_t c, input logic [3:0] exp);
        cpu.debug(1'b1, c);
        @(negedge clk);
        check("debug response", exp, dbg_rsp);
    endtask
    // mask clear is a one-cycle pulse in the first cycle of the low power mode
    task automatic enter(input logic is_stop);
        cpu.exec(is_stop);
        wait_mode(is_stop ? ST_STOP3 : ST_WAIT);
        check("mask clear", 1'b1, clear_imask);
        @(negedge clk);
        check("mask clear pulse", 1'b0, clear_imask);
    endtask
    task automatic expect_resume(input resume_t k, input pmode_t after);
        int n;
        wait_mode(ST_RESTORE);
        check("cpu clock restored", 1'b1, pwr_ctrl.cpu_clk_en);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (resume_go !== 1'b1 && n < 10);
        check("restore cycles", CLK_RESTORE_CYC, n);
        check("resume kind", k, resume_kind);
        check("mode after resume", after, mode);
    endtask
    task automatic wake(input logic irq, input logic rst, input logic [WAKE_W-1:0] src, input resume_t k,
                        input pmode_t after);
        cpu.levels(irq, rst, src);
        expect_resume(k, after);
        cpu.levels(1'b0, 1'b0, '0);
    endtask
    task automatic leave_bdm;
        cpu.levels(1'b0, 1'b1, '0);
        wait_mode(ST_RUN);
        cpu.levels(1'b0, 1'b0, '0);
    endtask

    task automatic t_reset;
        @(negedge clk);
        check("mode", ST_RUN, mode);
        check("vector", 16'hFFFE, fetch_vector);
        check("full regulation", 1'b1, pwr_ctrl.reg_full);
    endtask
    task automatic t_regs;
        logic [7:0]  ofs [4] = '{OFS_SYS_OPTION, OFS_DBG_STATUS, OFS_PWR_CTRL1, OFS_RTC_CTRL2};
        logic [31:0] val [4] = '{32'h0000_0007, 32'h0000_0001, 32'h0000_0003, 32'h0000_000F};
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 4; i++) begin
            rd_chk("reset value", ofs[i], 32'h0000_0000);
            wr_reg(ofs[i], val[i]);
            rd_chk("read back", ofs[i], val[i]);
            wr_reg(ofs[i], 32'h0000_0000);
        end
        // status is read-only, so a write must leave the mode field at run
        wr_reg(OFS_MODE_STATUS, 32'h0000_0007);
        apb(1'b0, OFS_MODE_STATUS, 32'h0000_0000, rd, err);
        check("status mode", 3'h0, rd[2:0]);
        apb(1'b0, 8'h14, 32'h0000_0000, rd, err);
        check("unmapped error", 1'b1, err);
        check("unmapped data", 32'h0000_0000, rd);
    endtask
    task automatic t_wait;
        enter(1'b0);
        check("wait clocks", 2'b01, {pwr_ctrl.cpu_clk_en, pwr_ctrl.bus_clk_en});
        check("full regulation", 1'b1, pwr_ctrl.reg_full);
        dbg_chk(CMD_MEM_STATUS, 4'b1010);
        dbg_chk(CMD_OTHER, 4'b0100);
        cpu.debug(1'b0, CMD_OTHER);
        @(negedge clk);
        check("still waiting", ST_WAIT, mode);
        wake(1'b1, 1'b0, '0, RESUME_IRQ, ST_RUN);
        enter(1'b0);
        dbg_chk(CMD_BACKGROUND, 4'b1000);
        cpu.debug(1'b0, CMD_OTHER);
        expect_resume(RESUME_BDM, ST_BDM);
        dbg_chk(CMD_OTHER, 4'b1000);
        dbg_chk(CMD_MEM_STATUS, 4'b1001);
        cpu.debug(1'b0, CMD_OTHER);
        leave_bdm();
    endtask
    task automatic t_stop;
        cpu.exec(1'b1);
        repeat (3) @(negedge clk);
        check("no stop without permit", ST_RUN, mode);
        wr_reg(OFS_SYS_OPTION, 32'h0000_0001);
        for (int i = 0; i < WAKE_W; i++) begin
            enter(1'b1);
            check("stop controls", 9'b0_0000_1011, pwr_ctrl);
            dbg_chk(CMD_BACKGROUND, 4'b0100);
            cpu.debug(1'b0, CMD_OTHER);
            wake(1'b0, 1'b0, WAKE_W'(1) << i, RESUME_IRQ, ST_RUN);
        end
        rd_chk("kept option", OFS_SYS_OPTION, 32'h0000_0001);
        wr_reg(OFS_SYS_OPTION, 32'h0000_0007);
        enter(1'b1);
        check("stop oscillators", 9'b0_0011_1011, pwr_ctrl);
        wake(1'b0, 1'b1, '0, RESUME_RESET, ST_RUN);
    endtask
    task automatic t_stop_debug;
        wr_reg(OFS_SYS_OPTION, 32'h0000_0001);
        wr_reg(OFS_DBG_STATUS, 32'h0000_0001);
        enter(1'b1);
        check("debug clock and regulation", 2'b11, {pwr_ctrl.dbg_clk_en, pwr_ctrl.reg_full});
        dbg_chk(CMD_MEM_STATUS, 4'b1010);
        dbg_chk(CMD_BACKGROUND, 4'b1000);
        cpu.debug(1'b0, CMD_OTHER);
        expect_resume(RESUME_BDM, ST_BDM);
        leave_bdm();
    endtask
    task automatic t_vd;
        wr_reg(OFS_SYS_OPTION, 32'h0000_0001);
        wr_reg(OFS_DBG_STATUS, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            wr_reg(OFS_PWR_CTRL1, i == 0 ? 32'h0000_0003 : 32'h0000_0001);
            enter(1'b1);
            check("stop regulation", i == 0, pwr_ctrl.reg_full);
            wake(1'b0, 1'b0, 7'h40, RESUME_IRQ, ST_RUN);
        end
    endtask
    task automatic t_run_bg;
        wr_reg(OFS_DBG_STATUS, 32'h0000_0000);
        dbg_chk(CMD_BACKGROUND, 4'b0100);
        @(negedge clk);
        check("mode", ST_RUN, mode);
        cpu.debug(1'b0, CMD_OTHER);
        wr_reg(OFS_DBG_STATUS, 32'h0000_0001);
        dbg_chk(CMD_BACKGROUND, 4'b1000);
        cpu.debug(1'b0, CMD_OTHER);
        wait_mode(ST_BDM);
        leave_bdm();
    endtask
    task automatic t_rtc;
        int ticks, rtc;
        for (int ps = 0; ps < 2; ps++) begin
            wr_reg(OFS_RTC_CTRL2, 32'(ps));
            ticks = 0;
            rtc = 0;
            repeat (2 * LPO_SIM) begin
                @(negedge clk);
                ticks += int'(lpo_tick === 1'b1);
                rtc += int'(rtc_clk_en === 1'b1);
            end
            check("lpo ticks", 2, ticks);
            check("rtc ticks", 2 * ps, rtc);
        end
    endtask

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_wait();
        t_stop();
        t_stop_debug();
        t_vd();
        t_run_bg();
        t_rtc();
        wrap_up();
    end
endmodule
